// ==== hdl/ltmc_mode_ctrl.v ====
/*
  Operating-mode controller of a LIN transceiver with an on-chip regulator.
  Sequences five modes and gates transmitter, receiver, regulator, wake
  detector, bus pull-up, watchdog enable and the reset output from the mode.
  Assumes threshold flags and pins arrive as plain logic levels, possibly
  asynchronous; the fault/transmit-enable pin is open drain, resolved outside.
  Every decision lags its inputs by the synchroniser depth plus one edge (a bus wake by plus two edges), and
  pulses shorter than one clock may be missed. The host must stop driving the
  fault/transmit-enable pin high while this block pulls it low for a fault.
  The bus wake debounce count must fit the wake detector's counter width.
*/
`include "ltmc_defines.vh"

module ltmc_mode_ctrl #(
  parameter SYNC_STAGES  = `LTMC_SYNC_STAGES,
  parameter DEBOUNCE_CYC = `LTMC_DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire                    clk,
  input  wire                    rst_n,
  // Supply and regulator flags
  input  wire                    battery_below_off,
  input  wire                    battery_above_on,
  input  wire                    regulator_ok,
  input  wire                    regulator_fault,
  input  wire                    internal_fault,
  // Host control pins
  input  wire                    select_wake_input,
  input  wire                    fault_txen_in,
  input  wire                    txd_in,
  // Bus comparators
  input  wire                    lin_bus_dominant,
  input  wire                    bus_below_wake,
  // Fault/transmit-enable open-drain pin drive
  output reg                     fault_txen_out,
  output reg                     fault_txen_oe,
  // Mode and gating outputs
  output reg  [`LTMC_MODE_W-1:0] mode,
  output reg                     digital_rst_n,
  output reg                     reset_out_n,
  output reg                     regulator_enable,
  output reg                     regulator_low_power,
  output reg                     tx_enable,
  output reg                     rx_enable,
  output reg                     wake_detect_enable,
  output reg                     bus_pullup_enable,
  output reg                     watchdog_enable,
  // Bus data
  output reg                     rxd_out,
  output reg                     lin_drive_low
);

  localparam [`LTMC_MODE_W-1:0] M_POR   = `LTMC_MODE_POR;
  localparam [`LTMC_MODE_W-1:0] M_READY = `LTMC_MODE_READY;
  localparam [`LTMC_MODE_W-1:0] M_OPER  = `LTMC_MODE_OPER;
  localparam [`LTMC_MODE_W-1:0] M_TXOFF = `LTMC_MODE_TXOFF;
  localparam [`LTMC_MODE_W-1:0] M_PDOWN = `LTMC_MODE_PDOWN;

  // Bit positions in the synchronised bundle; must match the raw_in order
  localparam I_BAT_LOW = 0;
  localparam I_BAT_ON  = 1;
  localparam I_REG_OK  = 2;
  localparam I_REG_FLT = 3;
  localparam I_INT_FLT = 4;
  localparam I_SEL     = 5;
  localparam I_FTE_PIN = 6;
  localparam I_TXD     = 7;
  localparam I_BUS_DOM = 8;
  localparam I_BUS_WK  = 9;
  localparam N_IN      = 10;

  // Synchronised levels
  wire [N_IN-1:0] raw_in;
  wire [N_IN-1:0] syn;
  wire       s_bat_low;
  wire       s_bat_on;
  wire       s_reg_ok;
  wire       s_reg_flt;
  wire       s_int_flt;
  wire       s_sel;
  wire       s_fte_pin;
  wire       s_txd;
  wire       s_bus_dom;
  wire       s_bus_wk;

  // Derived and registered state
  reg  [`LTMC_MODE_W-1:0] mode_ff;
  reg  [`LTMC_MODE_W-1:0] nxt_mode;
  reg                     sel_prev_ff;
  reg                     fte_prev_ff;
  wire                    fte_eff;
  wire                    sel_fall;
  wire                    fte_fall;
  wire                    bus_wake;
  wire                    go_oper;
  wire                    tx_ok;
  wire                    tx_gate;
  wire                    rx_gate;
  wire                    wake_arm;

  // Gate a transmitter request by the health conditions
  function tx_allowed;
    input [`LTMC_MODE_W-1:0] m;
    input                    reg_ok;
    input                    reg_flt;
    input                    int_flt;
    begin
      tx_allowed = (m == M_OPER) && reg_ok && !reg_flt && !int_flt;
    end
  endfunction

  // Receiver powered in ready, operation and transmitter off
  function rx_on;
    input [`LTMC_MODE_W-1:0] m;
    begin
      rx_on = (m == M_READY) || (m == M_OPER) || (m == M_TXOFF);
    end
  endfunction

  // Watchdog runs in ready and operation only
  function wdog_on;
    input [`LTMC_MODE_W-1:0] m;
    begin
      wdog_on = (m == M_READY) || (m == M_OPER);
    end
  endfunction

  // Regulator in reduced power in ready and transmitter off
  function low_power_on;
    input [`LTMC_MODE_W-1:0] m;
    begin
      low_power_on = (m == M_READY) || (m == M_TXOFF);
    end
  endfunction

  // Bundle the asynchronous inputs for the synchroniser
  assign raw_in = {bus_below_wake, lin_bus_dominant, txd_in, fault_txen_in,
                   select_wake_input, internal_fault, regulator_fault,
                   regulator_ok, battery_above_on, battery_below_off};

  // Two-stage synchroniser on every level
  ltmc_sync #(
    .WIDTH   (N_IN),
    .STAGES  (SYNC_STAGES),
    .RST_VAL (`LTMC_SYNC_RST)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (raw_in),
    .dout  (syn)
  );

  assign s_bat_low = syn[I_BAT_LOW];
  assign s_bat_on  = syn[I_BAT_ON];
  assign s_reg_ok  = syn[I_REG_OK];
  assign s_reg_flt = syn[I_REG_FLT];
  assign s_int_flt = syn[I_INT_FLT];
  assign s_sel     = syn[I_SEL];
  assign s_fte_pin = syn[I_FTE_PIN];
  assign s_txd     = syn[I_TXD];
  assign s_bus_dom = syn[I_BUS_DOM];
  assign s_bus_wk  = syn[I_BUS_WK];

  // Effective fault/txen level: low on pin low or internal fault
  assign fte_eff = s_fte_pin && !s_int_flt;

  // Edge history of the synchronised control pins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_prev_ff <= 1'b0;
      fte_prev_ff <= 1'b0;
    end else begin
      sel_prev_ff <= s_sel;
      fte_prev_ff <= fte_eff;
    end
  end

  assign sel_fall = sel_prev_ff && !s_sel;
  assign fte_fall = fte_prev_ff && !fte_eff;

  // Wake detector only runs in power-down
  assign wake_arm = (mode_ff == M_PDOWN);

  ltmc_wake_det #(
    .CNT_W        (`LTMC_DEBOUNCE_W),
    .DEBOUNCE_CYC (DEBOUNCE_CYC)
  ) u_wake (
    .clk        (clk),
    .rst_n      (rst_n),
    .enable     (wake_arm),
    .below_wake (s_bus_wk),
    .wake_pulse (bus_wake)
  );

  // Entry condition into operation
  assign tx_ok   = !s_reg_flt && s_reg_ok;
  assign go_oper = tx_ok && s_sel && fte_eff && s_txd;

  // Next-mode logic
  always @* begin
    nxt_mode = mode_ff;
    if (s_bat_low) begin
      nxt_mode = M_POR;
    end else begin
      case (mode_ff)
        M_POR: begin
          // Supply good enough to start the regulator
          if (s_bat_on) begin
            nxt_mode = M_READY;
          end
        end
        M_READY: begin
          // Wait for stable regulator and select high
          if (s_reg_ok && s_sel) begin
            if (go_oper) begin
              nxt_mode = M_OPER;
            end else if (!fte_eff) begin
              nxt_mode = M_TXOFF;
            end
          end
        end
        M_OPER: begin
          // Select low wins over a fault/txen drop
          if (sel_fall || !s_sel) begin
            nxt_mode = M_PDOWN;
          end else if (fte_fall || !fte_eff) begin
            nxt_mode = M_TXOFF;
          end
        end
        M_TXOFF: begin
          // Select low first, then a healthy return to operation
          if (!s_sel) begin
            nxt_mode = M_PDOWN;
          end else if (go_oper) begin
            nxt_mode = M_OPER;
          end
        end
        M_PDOWN: begin
          // Remote or local wake both restart through ready
          if (bus_wake || s_sel) begin
            nxt_mode = M_READY;
          end
        end
        default: begin
          // Unused codes fall back to reset
          nxt_mode = M_POR;
        end
      endcase
    end
  end

  // Gates decoded from the next mode, shared by enables and data outputs
  assign rx_gate = rx_on(nxt_mode);
  assign tx_gate = tx_allowed(nxt_mode, s_reg_ok, s_reg_flt, s_int_flt);

  // Mode register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= M_POR;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Registered gating outputs, decoded from the next mode
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode                <= M_POR;
      digital_rst_n       <= 1'b0;
      reset_out_n         <= 1'b0;
      regulator_enable    <= 1'b0;
      regulator_low_power <= 1'b0;
      tx_enable           <= 1'b0;
      rx_enable           <= 1'b0;
      wake_detect_enable  <= 1'b0;
      bus_pullup_enable   <= 1'b0;
      watchdog_enable     <= 1'b0;
    end else begin
      mode             <= nxt_mode;
      // Digital section and reset output held in power-on reset
      digital_rst_n    <= (nxt_mode != M_POR);
      reset_out_n      <= (nxt_mode != M_POR) && (nxt_mode != M_PDOWN)
                          && s_reg_ok;
      // Regulator on everywhere except power-on reset and power-down
      regulator_enable <= rx_gate;
      regulator_low_power <= low_power_on(nxt_mode);
      // Transmitter only in healthy operation
      tx_enable        <= tx_gate;
      // Receiver, wake detector, pull-up and watchdog per mode
      rx_enable        <= rx_gate;
      wake_detect_enable <= (nxt_mode == M_PDOWN);
      bus_pullup_enable  <= (nxt_mode == M_OPER);
      watchdog_enable  <= wdog_on(nxt_mode);
    end
  end

  // Bus data path: receive and transmit
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_out       <= 1'b1;
      lin_drive_low <= 1'b0;
    end else begin
      // Receive follows the bus only with receiver on; recessive otherwise
      // Same gates as the enables, so data never lags a mode edge
      rxd_out       <= rx_gate ? !s_bus_dom : 1'b1;
      lin_drive_low <= tx_gate && !s_txd;
    end
  end

  // Open-drain fault indication pulls the pin low during an internal fault
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_txen_out <= 1'b0;
      fault_txen_oe  <= 1'b0;
    end else begin
      // Never driven high; the host supplies the high level
      fault_txen_out <= 1'b0;
      fault_txen_oe  <= s_int_flt;
    end
  end

endmodule // ltmc_mode_ctrl

// ==== pkg/ltmc_defines.vh ====
/*
  Constants for the LIN transceiver mode controller: mode codes, clock rate,
  synchroniser depth and the bus wake debounce timing.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef LTMC_DEFINES_VH
`define LTMC_DEFINES_VH

// Mode codes, 3 bits wide
`define LTMC_MODE_W        3
`define LTMC_MODE_POR      3'h0
`define LTMC_MODE_READY    3'h1
`define LTMC_MODE_OPER     3'h2
`define LTMC_MODE_TXOFF    3'h3
`define LTMC_MODE_PDOWN    3'h4

// Clock period of clk in ns (20 MHz)
`define LTMC_CLK_PERIOD_NS 50

// Synchroniser depth
`define LTMC_SYNC_STAGES   2

// Bus wake debounce time in ns, and its least cycle count (rounded up)
`define LTMC_DEBOUNCE_NS   80000
`define LTMC_DEBOUNCE_CYC  ((`LTMC_DEBOUNCE_NS + `LTMC_CLK_PERIOD_NS - 1) / `LTMC_CLK_PERIOD_NS)
`define LTMC_DEBOUNCE_W    11

// Reset values of the synchronised inputs
`define LTMC_SYNC_RST      10'h000

`endif

// ==== hdl/ltmc_sync.v ====
/*
  Multi-bit level synchroniser, one chain of flip-flops per bit.
  Assumes every bit is an independent level; no word coherence is implied.
*/
module ltmc_sync #(
  parameter WIDTH   = 1,
  parameter STAGES  = 2,
  parameter RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Levels in and out
  input  wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg [STAGES-1:0] chain_ff;
      // Shift chain; only the last stage is seen outside
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          chain_ff <= {STAGES{RST_VAL[g]}};
        end else begin
          chain_ff <= {chain_ff[STAGES-2:0], din[g]};
        end
      end
      assign dout[g] = chain_ff[STAGES-1];
    end
  endgenerate

endmodule // ltmc_sync

// ==== hdl/ltmc_wake_det.v ====
/*
  Bus wake detector: a low bus below the wake threshold for at least the
  debounce time, followed by a return above it, gives a one-cycle wake pulse.
  Assumes a synchronised comparator level and an enable high only in power-down.
*/
`include "ltmc_defines.vh"

module ltmc_wake_det #(
  parameter CNT_W        = `LTMC_DEBOUNCE_W,
  parameter DEBOUNCE_CYC = `LTMC_DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire clk,
  input  wire rst_n,
  // Control and comparator level
  input  wire enable,
  input  wire below_wake,
  // Result
  output reg  wake_pulse
);

  localparam [CNT_W-1:0] LIMIT = DEBOUNCE_CYC[CNT_W-1:0];

  reg [CNT_W-1:0] low_cnt_ff;
  reg             armed_ff;
  reg             below_prev_ff;

  // Debounce count of the low phase; the rising edge fires only when armed
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_ff    <= {CNT_W{1'b0}};
      armed_ff      <= 1'b0;
      below_prev_ff <= 1'b0;
      wake_pulse    <= 1'b0;
    end else begin
      below_prev_ff <= below_wake;
      wake_pulse    <= 1'b0;
      if (!enable) begin
        low_cnt_ff <= {CNT_W{1'b0}};
        armed_ff   <= 1'b0;
      end else if (below_wake) begin
        if (low_cnt_ff >= LIMIT - 1'b1) begin
          armed_ff <= 1'b1;
        end else begin
          low_cnt_ff <= low_cnt_ff + 1'b1;
        end
      end else begin
        low_cnt_ff <= {CNT_W{1'b0}};
        armed_ff   <= 1'b0;
        if (below_prev_ff && armed_ff) begin
          wake_pulse <= 1'b1;
        end
      end
    end
  end

endmodule // ltmc_wake_det

// ==== tb/ltmc_mode_checker.sv ====
/*
  Concurrent checks on mode gating and mode transitions.
  Assumes the 2-stage input synchronisers plus one output register.
*/
`include "ltmc_defines.vh"
module ltmc_mode_checker (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    rst_n,
  // Flags and pins
  input wire logic                    battery_below_off,
  input wire logic                    regulator_ok,
  input wire logic                    regulator_fault,
  input wire logic                    internal_fault,
  input wire logic                    select_wake_input,
  input wire logic                    fault_txen_in,
  input wire logic                    txd_in,
  // Device outputs
  input wire logic [`LTMC_MODE_W-1:0] mode,
  input wire logic                    fault_txen_oe,
  input wire logic                    reset_out_n,
  input wire logic                    regulator_enable,
  input wire logic                    tx_enable,
  input wire logic                    rx_enable,
  input wire logic                    wake_detect_enable,
  input wire logic                    bus_pullup_enable,
  input wire logic                    watchdog_enable,
  input wire logic                    rxd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Mode code and supply handling
  a_mode_legal: assert property (mode <= `LTMC_MODE_PDOWN)
    else $error("mode code out of range");
  a_lowbat_por: assert property (battery_below_off [*4] |-> mode == `LTMC_MODE_POR)
    else $error("low battery did not force reset mode");
  a_por_all_off: assert property (mode == `LTMC_MODE_POR |->
    !reset_out_n && !regulator_enable && !rx_enable && !tx_enable)
    else $error("reset mode left something on");
  // Transitions: ready exit and operation entry tied to their causes three edges back, power-down exit to its target
  a_ready_exit: assert property ($past(mode) == `LTMC_MODE_READY &&
    !(mode inside {`LTMC_MODE_READY, `LTMC_MODE_POR}) |->
    $past(regulator_ok, 3) && $past(select_wake_input, 3))
    else $error("ready left without regulator ok and select");
  a_oper_entry: assert property (mode == `LTMC_MODE_OPER &&
    $past(mode) != `LTMC_MODE_OPER |-> $past(regulator_ok, 3) && $past(txd_in, 3) &&
    $past(select_wake_input, 3) && $past(fault_txen_in, 3) && !$past(internal_fault, 3))
    else $error("operation entered without all conditions");
  a_wake_ready: assert property ($past(mode) == `LTMC_MODE_PDOWN &&
    mode != `LTMC_MODE_PDOWN |-> mode inside {`LTMC_MODE_READY, `LTMC_MODE_POR})
    else $error("power down left to a mode other than ready");
  // Gating per mode and faults
  a_pullup_oper: assert property (bus_pullup_enable == (mode == `LTMC_MODE_OPER))
    else $error("pull-up outside operation");
  a_txoff_gates: assert property (mode == `LTMC_MODE_TXOFF |->
    rx_enable && !tx_enable && !watchdog_enable)
    else $error("transmitter off gating wrong");
  a_fault_no_tx: assert property (internal_fault [*4] |-> !tx_enable && fault_txen_oe)
    else $error("internal fault did not block transmitter");
  a_regflt_no_tx: assert property (regulator_fault [*4] |-> !tx_enable)
    else $error("regulator fault did not block transmitter");
  a_pdown_gates: assert property (mode == `LTMC_MODE_PDOWN |->
    wake_detect_enable && !regulator_enable && !rx_enable && rxd_out)
    else $error("power down gating wrong");

  // Main scenarios
  c_oper: cover property (mode == `LTMC_MODE_OPER);
  c_txoff: cover property (mode == `LTMC_MODE_TXOFF ##1 mode == `LTMC_MODE_OPER);
  c_wake: cover property (mode == `LTMC_MODE_PDOWN ##1 mode == `LTMC_MODE_READY);
endmodule // ltmc_mode_checker

bind ltmc_mode_ctrl ltmc_mode_checker chk_u (.clk, .rst_n, .battery_below_off, .regulator_ok,
  .regulator_fault, .internal_fault, .select_wake_input, .fault_txen_in, .txd_in, .mode,
  .fault_txen_oe, .reset_out_n, .regulator_enable, .tx_enable, .rx_enable,
  .wake_detect_enable, .bus_pullup_enable, .watchdog_enable, .rxd_out);

// ==== tb/ltmc_host_model.sv ====
/*
  Host model driving the fault/transmit-enable pin push-pull.
  Assumes the device pulls the pin low through its output enable.
*/
module ltmc_host_model (
  // Clock
  input  wire logic clk,
  // Host intent and device drive
  input  wire logic want_txen,
  input  wire logic dev_out,
  input  wire logic dev_oe,
  // Resolved pin level
  output wire logic pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_hi_ff = 1'b0;
  // Host backs off its high drive while a fault is shown
  always @(posedge clk) host_hi_ff <= want_txen && !dev_oe;
  // Device pull-down wins over the host
  assign pin_level = dev_oe ? dev_out : host_hi_ff;
endmodule // ltmc_host_model

// ==== tb/tb_top.sv ====
/*
  Self-checking bench for the transceiver mode controller.
  Assumes the include path holds ltmc_defines.vh and the checker is bound.
*/
`include "ltmc_defines.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, bat_lo = 1, bat_hi = 0, reg_ok = 0, reg_flt = 0, int_flt = 0;
  logic sel = 0, want_txen = 0, txd = 1, dom = 0, below = 0;
  logic pin, ft_out, ft_oe, dig_n, rout_n, reg_en, reg_lp, tx_en, rx_en, wk_en, pu_en;
  logic wd_en, rxd, drv_lo;
  logic [`LTMC_MODE_W-1:0] mode, e, last_mode = 3'h0;
  logic [`LTMC_MODE_W-1:0] exp_q[$];
  int bad_count = 0, n_checks = 0, r;

  initial forever #25 clk = ~clk;

  ltmc_mode_ctrl #(.DEBOUNCE_CYC(8)) dut_u (.clk(clk), .rst_n(rst_n),
    .battery_below_off(bat_lo), .battery_above_on(bat_hi), .regulator_ok(reg_ok),
    .regulator_fault(reg_flt), .internal_fault(int_flt), .select_wake_input(sel),
    .fault_txen_in(pin), .txd_in(txd), .lin_bus_dominant(dom), .bus_below_wake(below),
    .fault_txen_out(ft_out), .fault_txen_oe(ft_oe), .mode(mode), .digital_rst_n(dig_n),
    .reset_out_n(rout_n), .regulator_enable(reg_en), .regulator_low_power(reg_lp),
    .tx_enable(tx_en), .rx_enable(rx_en), .wake_detect_enable(wk_en),
    .bus_pullup_enable(pu_en), .watchdog_enable(wd_en), .rxd_out(rxd), .lin_drive_low(drv_lo));
  ltmc_host_model host_u (.clk(clk), .want_txen(want_txen), .dev_out(ft_out),
    .dev_oe(ft_oe), .pin_level(pin));

  // Each mode change takes the oldest expected mode
  always @(negedge clk) begin
    if (rst_n && mode !== last_mode) begin
      e = exp_q.size() ? exp_q.pop_front() : 3'h7;
      `CHK("mode", e, mode)
      `CHK("pullup", e == `LTMC_MODE_OPER, pu_en)
      `CHK("regulator", e != `LTMC_MODE_POR && e != `LTMC_MODE_PDOWN, reg_en)
      `CHK("low power", e == `LTMC_MODE_READY || e == `LTMC_MODE_TXOFF, reg_lp)
      `CHK("watchdog", e == `LTMC_MODE_READY || e == `LTMC_MODE_OPER, wd_en)
      `CHK("wake det", e == `LTMC_MODE_PDOWN, wk_en)
      `CHK("reset out", e != `LTMC_MODE_POR && e != `LTMC_MODE_PDOWN && reg_ok, rout_n)
    end
    last_mode <= mode;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Wait, bounded, until every expected mode was seen
  task automatic settle();
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < 200) begin
      @(posedge clk);
      k++;
    end
    `CHK("pending", 0, exp_q.size())
    cyc(2);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard, far beyond the normal run
  initial begin
    cyc(3000);
    bad_count++;
    report_and_stop();
  end

  initial begin
    r = $urandom(41);
    cyc(2);
    rst_n <= 1;
    cyc(3);
    `CHK("reset out", 1'b0, rout_n)
    bat_lo <= 0;
    bat_hi <= 1;
    exp_q.push_back(`LTMC_MODE_READY);
    settle();
    `CHK("rx ready", 1'b1, rx_en)
    `CHK("tx ready", 1'b0, tx_en)
    // Select low, then transmit data low: ready holds
    reg_ok <= 1;
    want_txen <= 1;
    txd <= 0;
    cyc(10);
    sel <= 1;
    cyc(10);
    txd <= 1;
    exp_q.push_back(`LTMC_MODE_OPER);
    settle();
    want_txen <= 0;
    exp_q.push_back(`LTMC_MODE_TXOFF);
    settle();
    `CHK("watchdog", 1'b0, wd_en)
    want_txen <= 1;
    exp_q.push_back(`LTMC_MODE_OPER);
    settle();
    // Internal fault while the host still asks to transmit
    int_flt <= 1;
    exp_q.push_back(`LTMC_MODE_TXOFF);
    settle();
    `CHK("fault oe", 1'b1, ft_oe)
    `CHK("fault pin", 1'b0, pin)
    `CHK("fault out", 1'b0, ft_out)
    int_flt <= 0;
    exp_q.push_back(`LTMC_MODE_OPER);
    settle();
    reg_flt <= 1;
    txd <= 0;
    cyc(6);
    `CHK("tx regflt", 1'b0, tx_en)
    `CHK("drive regflt", 1'b0, drv_lo)
    reg_flt <= 0;
    // Random transmit data and bus levels
    repeat (12) begin
      txd <= 1'($urandom);
      dom <= 1'($urandom);
      cyc(5);
      `CHK("rxd", ~dom, rxd)
      `CHK("drive", ~txd, drv_lo)
    end
    txd <= 1;
    sel <= 0;
    exp_q.push_back(`LTMC_MODE_PDOWN);
    settle();
    // Short bus low ignored, long one wakes
    below <= 1;
    dom <= 1;
    cyc(4);
    below <= 0;
    cyc(10);
    `CHK("rxd pdown", 1'b1, rxd)
    below <= 1;
    cyc(20);
    below <= 0;
    exp_q.push_back(`LTMC_MODE_READY);
    settle();
    sel <= 1;
    dom <= 0;
    exp_q.push_back(`LTMC_MODE_OPER);
    settle();
    sel <= 0;
    exp_q.push_back(`LTMC_MODE_PDOWN);
    settle();
    sel <= 1;
    exp_q.push_back(`LTMC_MODE_READY);
    exp_q.push_back(`LTMC_MODE_OPER);
    settle();
    want_txen <= 0;
    exp_q.push_back(`LTMC_MODE_TXOFF);
    settle();
    sel <= 0;
    exp_q.push_back(`LTMC_MODE_PDOWN);
    settle();
    bat_lo <= 1;
    bat_hi <= 0;
    exp_q.push_back(`LTMC_MODE_POR);
    settle();
    `CHK("digital reset", 1'b0, dig_n)
    report_and_stop();
  end
endmodule // tb_top
